// [rtl/crt_timing_pkg.sv]
// Behaviour
// - Vertical registers count whole scan lines
// - One horizontal count is eight pixel clocks
// - Two timing register copies, one per resolution
// - Selected resolution's copy drives the timing
// - Line counter wraps after horizontal total blocks
// - Blank after horizontal active block count
// - Horizontal sync starts at programmed block
// - Twelve-bit vertical total sets lines per frame
// - Lines past vertical active count are blanked
// - Vertical sync starts at programmed line
// - Low five bits give vertical sync width
// - Bit five set makes vertical sync active-low
// - Display setup bit three doubles each line
// - Display setup bit four selects interlace
// - Enable field 01 runs, 10 resets display
// - Enable field always writable, even when locked
// - Mode select bit two picks resolution copy
`default_nettype none
package crt_timing_pkg;
    // ***************************
    // Register offsets
    // ***************************
    localparam logic [15:0] HORIZ_LINE_LENGTH_OFS = 16'h02e8;
    localparam logic [15:0] HORIZ_ACTIVE_LENGTH_OFS = 16'h06e8;
    localparam logic [15:0] HORIZ_SYNC_BEGIN_OFS = 16'h0ae8;
    localparam logic [15:0] HORIZ_SYNC_PULSE_OFS = 16'h0ee8;
    localparam logic [15:0] VERT_FRAME_LENGTH_OFS = 16'h12e8;
    localparam logic [15:0] VERT_ACTIVE_LENGTH_OFS = 16'h16e8;
    localparam logic [15:0] VERT_SYNC_BEGIN_OFS = 16'h1ae8;
    localparam logic [15:0] VERT_SYNC_PULSE_OFS = 16'h1ee8;
    localparam logic [15:0] DISPLAY_SETUP_OFS = 16'h22e8;
    localparam logic [15:0] GRAPHICS_MODE_SELECT_OFS = 16'h4ae8;
    localparam logic [15:0] SET_LOCK_OFS = 16'h0004;
    localparam logic [15:0] TIMING_STATUS_OFS = 16'h0008;

    // ***************************
    // Timing register copy indices
    // ***************************
    localparam int NUM_SETS = 2;
    localparam int NUM_TIM = 8;
    localparam logic [3:0] IDX_HTOT = 4'h0;
    localparam logic [3:0] IDX_HACT = 4'h1;
    localparam logic [3:0] IDX_HSB = 4'h2;
    localparam logic [3:0] IDX_HSP = 4'h3;
    localparam logic [3:0] IDX_VTOT = 4'h4;
    localparam logic [3:0] IDX_VACT = 4'h5;
    localparam logic [3:0] IDX_VSB = 4'h6;
    localparam logic [3:0] IDX_VSP = 4'h7;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // ***************************
    // Field positions
    // ***************************
    localparam int SYNC_WIDTH_LSB = 0;
    localparam int SYNC_WIDTH_W = 5;
    localparam int SYNC_POL_BIT = 5;
    localparam int RES_SEL_BIT = 2;
    localparam int DISP_DSCAN_BIT = 3;
    localparam int DISP_ILACE_BIT = 4;
    localparam int DISP_EN_LSB = 5;
    localparam int DISP_KEEP_W = 5;
    localparam logic [1:0] DISP_EN_RUN = 2'h1;
    localparam logic [1:0] DISP_EN_RESET = 2'h2;

    // ***************************
    // Reset values and timing counts
    // ***************************
    localparam logic [11:0] TIM_RST = 12'h000;
    localparam logic [4:0] DISP_RST = 5'h00;
    localparam logic [1:0] EN_FIELD_RST = 2'h0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] LOCK_RST = 2'h0;
    localparam int PIX_PER_BLOCK = 8;
    localparam logic [2:0] PIX_LAST = 3'(PIX_PER_BLOCK - 1);

    typedef enum logic [1:0] {DISP_HALT, DISP_ACTIVE} disp_state_e;
endpackage
`default_nettype wire

// [rtl/crt_video_timing_generator.sv]
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module crt_video_timing_generator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic hsync,
    output logic vsync,
    output logic blank,
    output logic video_en,
    output logic field
);
    import crt_timing_pkg::*;

    // ***************************
    // Register file
    // ***************************
    logic [NUM_TIM-1:0][11:0] tim_q [NUM_SETS];
    logic [DISP_KEEP_W-1:0] disp_q [NUM_SETS];
    logic [1:0] en_field_q;
    logic [7:0] mode_q;
    logic [1:0] lock_q;
    logic acc;
    logic wr;
    logic hit;
    logic [3:0] tidx;
    logic res_sel;

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;

    always_comb begin
        tidx = IDX_NONE;
        case (paddr)
            HORIZ_LINE_LENGTH_OFS: tidx = IDX_HTOT;
            HORIZ_ACTIVE_LENGTH_OFS: tidx = IDX_HACT;
            HORIZ_SYNC_BEGIN_OFS: tidx = IDX_HSB;
            HORIZ_SYNC_PULSE_OFS: tidx = IDX_HSP;
            VERT_FRAME_LENGTH_OFS: tidx = IDX_VTOT;
            VERT_ACTIVE_LENGTH_OFS: tidx = IDX_VACT;
            VERT_SYNC_BEGIN_OFS: tidx = IDX_VSB;
            VERT_SYNC_PULSE_OFS: tidx = IDX_VSP;
            default: tidx = IDX_NONE;
        endcase
    end

    assign hit = (tidx != IDX_NONE) || (paddr == DISPLAY_SETUP_OFS)
        || (paddr == GRAPHICS_MODE_SELECT_OFS) || (paddr == SET_LOCK_OFS)
        || (paddr == TIMING_STATUS_OFS);

    assign res_sel = mode_q[RES_SEL_BIT];

    // Per-resolution copies, writes land in the selected copy only
    genvar s;
    generate
        for (s = 0; s < NUM_SETS; s++) begin : g_set
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tim_q[s] <= {NUM_TIM{TIM_RST}};
                    disp_q[s] <= DISP_RST;
                end else if (wr && (res_sel == 1'(s)) && !lock_q[s]) begin
                    if (tidx != IDX_NONE) begin
                        tim_q[s][tidx[2:0]] <= pwdata[11:0];
                    end
                    if (paddr == DISPLAY_SETUP_OFS) begin
                        disp_q[s] <= pwdata[DISP_KEEP_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // Enable field ignores the lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_field_q <= EN_FIELD_RST;
        end else if (wr && paddr == DISPLAY_SETUP_OFS) begin
            en_field_q <= pwdata[DISP_EN_LSB+1:DISP_EN_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RST;
            lock_q <= LOCK_RST;
        end else if (wr) begin
            if (paddr == GRAPHICS_MODE_SELECT_OFS) begin
                mode_q <= pwdata[7:0];
            end
            if (paddr == SET_LOCK_OFS) begin
                lock_q <= pwdata[1:0];
            end
        end
    end

    // ***************************
    // Active copy
    // ***************************
    logic [7:0] htot, hact, hsb;
    logic [4:0] hwid, vwid;
    logic hpol, vpol, dscan, ilace;
    logic [11:0] vtot, vact, vsb;

    always_comb begin
        htot = tim_q[res_sel][IDX_HTOT][7:0];
        hact = tim_q[res_sel][IDX_HACT][7:0];
        hsb = tim_q[res_sel][IDX_HSB][7:0];
        hwid = tim_q[res_sel][IDX_HSP][SYNC_WIDTH_LSB+SYNC_WIDTH_W-1:SYNC_WIDTH_LSB];
        hpol = tim_q[res_sel][IDX_HSP][SYNC_POL_BIT];
        vtot = tim_q[res_sel][IDX_VTOT];
        vact = tim_q[res_sel][IDX_VACT];
        vsb = tim_q[res_sel][IDX_VSB];
        vwid = tim_q[res_sel][IDX_VSP][SYNC_WIDTH_LSB+SYNC_WIDTH_W-1:SYNC_WIDTH_LSB];
        vpol = tim_q[res_sel][IDX_VSP][SYNC_POL_BIT];
        dscan = disp_q[res_sel][DISP_DSCAN_BIT];
        ilace = disp_q[res_sel][DISP_ILACE_BIT];
    end

    // ***************************
    // Display state
    // ***************************
    disp_state_e st_q, st_d;

    always_comb begin
        case (en_field_q)
            DISP_EN_RUN: st_d = DISP_ACTIVE;
            DISP_EN_RESET: st_d = DISP_HALT;
            default: st_d = st_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= DISP_HALT;
        end else begin
            st_q <= st_d;
        end
    end

    // ***************************
    // Counters
    // ***************************
    logic [2:0] pix_q, pix_d;
    logic [7:0] hcnt_q, hcnt_d;
    logic [11:0] vcnt_q, vcnt_d;
    logic [4:0] hs_left_q, hs_left_d, vs_left_q, vs_left_d;
    logic rep_q, rep_d, fld_q, fld_d;
    logic line_last, frame_last, block_end;

    assign block_end = (pix_q == PIX_LAST);
    assign line_last = ({1'b0, hcnt_q} + 9'h001) >= {1'b0, htot};
    assign frame_last = ({1'b0, vcnt_q} + 13'h0001)
        >= ({1'b0, vtot} + {12'h000, ilace & fld_q});

    always_comb begin
        pix_d = pix_q;
        hcnt_d = hcnt_q;
        vcnt_d = vcnt_q;
        hs_left_d = hs_left_q;
        vs_left_d = vs_left_q;
        rep_d = rep_q;
        fld_d = fld_q;
        if (st_q == DISP_HALT) begin
            pix_d = 3'h0;
            hcnt_d = 8'h00;
            vcnt_d = 12'h000;
            hs_left_d = 5'h00;
            vs_left_d = 5'h00;
            rep_d = 1'b0;
            fld_d = 1'b0;
        end else if (block_end) begin
            pix_d = 3'h0;
            if (line_last) begin
                hcnt_d = 8'h00;
                if (!dscan || rep_q) begin
                    rep_d = 1'b0;
                    if (frame_last) begin
                        vcnt_d = 12'h000;
                        fld_d = ilace & ~fld_q;
                    end else begin
                        vcnt_d = vcnt_q + 12'h001;
                    end
                    if (vcnt_d == vsb && vwid != 5'h00) begin
                        vs_left_d = vwid;
                    end else if (vs_left_q != 5'h00) begin
                        vs_left_d = vs_left_q - 5'h01;
                    end
                end else begin
                    rep_d = 1'b1;
                end
            end else begin
                hcnt_d = hcnt_q + 8'h01;
            end
            if (hcnt_d == hsb && hwid != 5'h00) begin
                hs_left_d = hwid;
            end else if (hs_left_q != 5'h00) begin
                hs_left_d = hs_left_q - 5'h01;
            end
        end else begin
            pix_d = pix_q + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_q <= 3'h0;
            hcnt_q <= 8'h00;
            vcnt_q <= 12'h000;
            hs_left_q <= 5'h00;
            vs_left_q <= 5'h00;
            rep_q <= 1'b0;
            fld_q <= 1'b0;
        end else begin
            pix_q <= pix_d;
            hcnt_q <= hcnt_d;
            vcnt_q <= vcnt_d;
            hs_left_q <= hs_left_d;
            vs_left_q <= vs_left_d;
            rep_q <= rep_d;
            fld_q <= fld_d;
        end
    end

    // ***************************
    // Video outputs
    // ***************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsync <= 1'b0;
            vsync <= 1'b0;
            blank <= 1'b1;
            video_en <= 1'b0;
            field <= 1'b0;
        end else begin
            hsync <= (hs_left_d != 5'h00) ^ hpol;
            vsync <= (vs_left_d != 5'h00) ^ vpol;
            blank <= (st_d != DISP_ACTIVE) || (hcnt_d >= hact)
                || (vcnt_d >= vact);
            video_en <= (st_d == DISP_ACTIVE);
            field <= fld_d;
        end
    end

    // ***************************
    // APB answer
    // ***************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                if (paddr == SET_LOCK_OFS) begin
                    prdata <= {30'h0000_0000, lock_q};
                end else if (paddr == TIMING_STATUS_OFS) begin
                    prdata <= {8'h00, fld_q, st_q == DISP_ACTIVE, hs_left_q != 5'h00,
                        vs_left_q != 5'h00, vcnt_q, hcnt_q};
                end
            end
        end
    end

    // ***************************
    // Assertions
    // ***************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic run2;
    assign run2 = (st_q == DISP_ACTIVE) && (st_d == DISP_ACTIVE);
    logic vstep;
    assign vstep = run2 && block_end && line_last && (!dscan || rep_q);

    sequence s_line_wrap;
        run2 && block_end && line_last;
    endsequence

    sequence s_hs_trigger;
        run2 && block_end && !line_last && (hcnt_q + 8'h01 == hsb) && hwid != 5'h00;
    endsequence

    sequence s_frame_wrap;
        vstep && frame_last;
    endsequence

    sequence s_line_step;
        vstep && !frame_last;
    endsequence

    sequence s_vs_trigger;
        vstep && !frame_last && (vcnt_q + 12'h001 == vsb) && vwid != 5'h00;
    endsequence

    property p_block_div;
        run2 && !block_end |=> $stable(hcnt_q);
    endproperty
    a_block_div: assert property (p_block_div) else $error("line count moved mid block");

    property p_line_wrap;
        s_line_wrap |=> hcnt_q == 8'h00;
    endproperty
    a_line_wrap: assert property (p_line_wrap) else $error("line count did not wrap");

    property p_hs_start;
        s_hs_trigger |=> hs_left_q == $past(hwid);
    endproperty
    a_hs_start: assert property (p_hs_start) else $error("horizontal sync not started");

    property p_hblank;
        run2 && $stable(hact) && hcnt_q >= hact |-> blank;
    endproperty
    a_hblank: assert property (p_hblank) else $error("blank missing past active");

    property p_vpol;
        $stable(vpol) && !$rose(presetn) |=> vsync == ((vs_left_q != 5'h00) ^ $past(vpol));
    endproperty
    a_vpol: assert property (p_vpol) else $error("vertical sync level wrong");

    property p_lock0;
        lock_q[0] |=> $stable(tim_q[0]) && $stable(disp_q[0]);
    endproperty
    a_lock0: assert property (p_lock0) else $error("locked copy changed");

    property p_en_write;
        wr && paddr == DISPLAY_SETUP_OFS |=> en_field_q == $past(pwdata[6:5]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable field not written");

    property p_halt;
        st_q == DISP_HALT |-> blank && !video_en ##1 pix_q == 3'h0;
    endproperty
    a_halt: assert property (p_halt) else $error("reset display not blanked");

    property p_dscan;
        s_line_wrap and (dscan && !rep_q) |=> $stable(vcnt_q) && rep_q;
    endproperty
    a_dscan: assert property (p_dscan) else $error("double scan did not repeat line");

    property p_lock1;
        lock_q[1] |=> $stable(tim_q[1]) && $stable(disp_q[1]);
    endproperty
    a_lock1: assert property (p_lock1) else $error("locked higher copy changed");

    property p_vblank;
        run2 && $stable(vact) && vcnt_q >= vact |-> blank;
    endproperty
    a_vblank: assert property (p_vblank) else $error("blank missing past active lines");

    property p_frame_wrap;
        s_frame_wrap |=> vcnt_q == 12'h000;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("line counter did not wrap");

    property p_line_step;
        s_line_step |=> vcnt_q == $past(vcnt_q) + 12'h001;
    endproperty
    a_line_step: assert property (p_line_step) else $error("line counter did not step");

    property p_vs_start;
        s_vs_trigger |=> vs_left_q == $past(vwid);
    endproperty
    a_vs_start: assert property (p_vs_start) else $error("vertical sync not started");

    property p_field_toggle;
        s_frame_wrap ##0 ilace |=> fld_q != $past(fld_q);
    endproperty
    a_field_toggle: assert property (p_field_toggle) else $error("field did not toggle");

    property p_en_run;
        wr && paddr == DISPLAY_SETUP_OFS && pwdata[DISP_EN_LSB+1:DISP_EN_LSB] == DISP_EN_RUN
            |=> ##1 video_en;
    endproperty
    a_en_run: assert property (p_en_run) else $error("display not enabled");

    property p_en_reset;
        wr && paddr == DISPLAY_SETUP_OFS && pwdata[DISP_EN_LSB+1:DISP_EN_LSB] == DISP_EN_RESET
            |=> ##1 blank && !video_en;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("display not held in reset");
endmodule
`default_nettype wire

// [verif/crt_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module crt_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic blank,
    input wire logic hpol,
    input wire logic vpol,
    output logic [15:0] h_period,
    output logic [15:0] h_width,
    output logic [15:0] h_lead,
    output logic [15:0] v_period,
    output logic [15:0] v_width,
    output logic [15:0] v_lead,
    output logic [15:0] act_clk
);
    // ***************************
    // Screen side measurements
    // ***************************
    logic hs, vs, hs_q, vs_q, blank_q, armed;
    logic [15:0] hc, hw, vc, vw, bc, ac;
    assign hs = hsync ^ hpol;
    assign vs = vsync ^ vpol;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hs_q, vs_q, blank_q, armed} <= 4'h0;
            {hc, hw, vc, vw, bc, ac} <= '0;
            {h_period, h_width, h_lead, v_period, v_width, v_lead, act_clk} <= '0;
        end else begin
            hs_q <= hs;
            vs_q <= vs;
            blank_q <= blank;
            hc <= (hs && !hs_q) ? 16'h1 : hc + 16'h1;
            vc <= (vs && !vs_q) ? 16'h1 : vc + 16'h1;
            hw <= hs ? hw + 16'h1 : 16'h0;
            vw <= vs ? vw + 16'h1 : 16'h0;
            bc <= (blank && !blank_q) ? 16'h1 : bc + 16'h1;
            if (hs && !hs_q) begin
                h_period <= hc;
            end
            if (!hs && hs_q) begin
                h_width <= hw;
            end
            if (!vs && vs_q) begin
                v_width <= vw;
            end
            // Sync lead measured from end of active video
            if (hs && !hs_q && armed) begin
                h_lead <= bc;
                armed <= 1'b0;
            end
            if (blank && !blank_q) begin
                armed <= 1'b1;
            end
            if (vs && !vs_q) begin
                v_period <= vc;
                v_lead <= bc;
                act_clk <= ac;
                ac <= 16'h0;
            end else if (!blank) begin
                ac <= ac + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import crt_timing_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, hsync, vsync, blank, video_en, field, er, f0;
    logic hpol = 1'b0;
    logic vpol = 1'b0;
    logic [15:0] h_period, h_width, h_lead, v_period, v_width, v_lead, act_clk;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2 pclk = ~pclk;

    crt_video_timing_generator DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsync(hsync),
        .vsync(vsync), .blank(blank), .video_en(video_en), .field(field));

    crt_monitor monitor (.pclk(pclk), .presetn(presetn), .hsync(hsync), .vsync(vsync),
        .blank(blank), .hpol(hpol), .vpol(vpol), .h_period(h_period), .h_width(h_width),
        .h_lead(h_lead), .v_period(v_period), .v_width(v_width), .v_lead(v_lead),
        .act_clk(act_clk));

    // ***************************
    // Bus and check tasks
    // ***************************
    task automatic complete_run;
        $display("Counts: %0d mismatches in %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 45000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic prog(input logic [7:0] ht, ha, hb, hp, input logic [11:0] vt, va, vb,
                        input logic [7:0] vp, ds);
        wr(HORIZ_LINE_LENGTH_OFS, {24'h0, ht});
        wr(HORIZ_ACTIVE_LENGTH_OFS, {24'h0, ha});
        wr(HORIZ_SYNC_BEGIN_OFS, {24'h0, hb});
        wr(HORIZ_SYNC_PULSE_OFS, {24'h0, hp});
        wr(VERT_FRAME_LENGTH_OFS, {20'h0, vt});
        wr(VERT_ACTIVE_LENGTH_OFS, {20'h0, va});
        wr(VERT_SYNC_BEGIN_OFS, {20'h0, vb});
        wr(VERT_SYNC_PULSE_OFS, {24'h0, vp});
        wr(DISPLAY_SETUP_OFS, {24'h0, ds});
    endtask

    task automatic settle;
        repeat (3000) @(posedge pclk);
    endtask

    // ***************************
    // Scenarios
    // ***************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("blank", 32'h1, {31'h0, blank});
        chk("video_en", 32'h0, {31'h0, video_en});
        // Lower copy: 6 blocks, 4 active, sync at 5 width 1; 10 lines, 6 active
        prog(8'h06, 8'h04, 8'h05, 8'h01, 12'h00a, 12'h006, 12'h007, 8'h02, 8'h20);
        settle;
        chk("h_period", 32'h30, {16'h0, h_period});
        chk("h_width", 32'h8, {16'h0, h_width});
        chk("h_lead", 32'h8, {16'h0, h_lead});
        chk("act_clk", 32'hc0, {16'h0, act_clk});
        chk("v_period", 32'h1e0, {16'h0, v_period});
        chk("v_width", 32'h60, {16'h0, v_width});
        chk("v_lead", 32'h40, {16'h0, v_lead});
        chk("video_en", 32'h1, {31'h0, video_en});
        chk("field", 32'h0, {31'h0, field});
        // Locked copy keeps timing but obeys the enable field
        wr(SET_LOCK_OFS, 32'h1);
        wr(HORIZ_LINE_LENGTH_OFS, 32'h9);
        wr(DISPLAY_SETUP_OFS, 32'h40);
        repeat (4) @(posedge pclk);
        chk("video_en", 32'h0, {31'h0, video_en});
        chk("blank", 32'h1, {31'h0, blank});
        xfer(1'b0, SET_LOCK_OFS, 32'h0);
        chk("lock", 32'h1, rd);
        xfer(1'b0, TIMING_STATUS_OFS, 32'h0);
        chk("status", 32'h0, rd);
        wr(DISPLAY_SETUP_OFS, 32'h20);
        settle;
        chk("h_period", 32'h30, {16'h0, h_period});
        chk("video_en", 32'h1, {31'h0, video_en});
        wr(SET_LOCK_OFS, 32'h0);
        // Higher copy with both syncs active low
        wr(GRAPHICS_MODE_SELECT_OFS, 32'h4);
        hpol <= 1'b1;
        vpol <= 1'b1;
        prog(8'h05, 8'h03, 8'h04, 8'h21, 12'h00a, 12'h006, 12'h007, 8'h22, 8'h20);
        settle;
        chk("h_period", 32'h28, {16'h0, h_period});
        chk("h_width", 32'h8, {16'h0, h_width});
        chk("v_width", 32'h50, {16'h0, v_width});
        chk("act_clk", 32'h90, {16'h0, act_clk});
        chk("v_period", 32'h190, {16'h0, v_period});
        // Higher copy locked keeps its line length
        wr(SET_LOCK_OFS, 32'h2);
        wr(HORIZ_LINE_LENGTH_OFS, 32'h9);
        repeat (200) @(posedge pclk);
        chk("h_period", 32'h28, {16'h0, h_period});
        // Back to the lower copy, untouched by the higher one
        hpol <= 1'b0;
        vpol <= 1'b0;
        wr(GRAPHICS_MODE_SELECT_OFS, 32'h0);
        settle;
        chk("h_period", 32'h30, {16'h0, h_period});
        chk("v_width", 32'h60, {16'h0, v_width});
        // Double scan, then interlace
        wr(DISPLAY_SETUP_OFS, 32'h28);
        settle;
        chk("v_period", 32'h3c0, {16'h0, v_period});
        wr(DISPLAY_SETUP_OFS, 32'h30);
        settle;
        @(posedge vsync);
        f0 = field;
        @(posedge vsync);
        chk("field", {31'h0, ~f0}, {31'h0, field});
        // Enable field 00 keeps the display running
        wr(DISPLAY_SETUP_OFS, 32'h10);
        repeat (4) @(posedge pclk);
        chk("video_en", 32'h1, {31'h0, video_en});
        xfer(1'b0, TIMING_STATUS_OFS, 32'h0);
        chk("active", 32'h1, {31'h0, rd[22]});
        // Write-only read and unmapped place
        xfer(1'b0, HORIZ_LINE_LENGTH_OFS, 32'h0);
        chk("rdata", 32'h0, rd);
        chk("slverr", 32'h0, {31'h0, er});
        xfer(1'b0, 16'h0010, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        xfer(1'b1, 16'h0010, 32'h5);
        chk("slverr", 32'h1, {31'h0, er});
        complete_run();
    end
endmodule
`default_nettype wire
